/* File: slhfp_host.sv */
`timescale 1ns/1ps
module slhfp_host
   import slhfp_pkg::*;
(
   input wire logic clock,
   output logic cs_n,
   output logic rd_n,
   output logic wr_n,
   output logic sel,
   output logic [ADDR_HI:ADDR_LO] addr,
   output logic [DATA_W-1:0] data
);
   initial begin
      {cs_n, rd_n, wr_n, sel, addr, data} = PINS_IDLE;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : hold
   task automatic rd_on(input logic s, input logic [ADDR_HI:ADDR_LO] a);
      sel = s;
      addr = a;
      cs_n = 1'b0;
      rd_n = 1'b0;
      hold(17);
   endtask : rd_on
   task automatic next_addr(input logic [ADDR_HI:ADDR_LO] a);
      addr = a;
      hold(17);
   endtask : next_addr
   task automatic rd_off;
      cs_n = 1'b1;
      rd_n = 1'b1;
      hold(6);
   endtask : rd_off
   task automatic wr(input logic s, input logic [ADDR_HI:ADDR_LO] a,
      input logic [DATA_W-1:0] d);
      sel = s;
      addr = a;
      data = d;
      cs_n = 1'b0;
      wr_n = 1'b0;
      hold(17);
      cs_n = 1'b1;
      wr_n = 1'b1;
      // Released bus shows no stale word
      data = ~d;
      hold(6);
   endtask : wr
endmodule : slhfp_host

/* File: slhfp_pin_if.sv */
`timescale 1ns/1ps
interface slhfp_pin_if;
   import slhfp_pkg::*;
   slhfp_pins_t raw;
   slhfp_pins_t filt;
   modport sampler (input raw, output filt);
   modport user (output raw, input filt);
endinterface : slhfp_pin_if

/* File: slhfp_pkg.sv */
package slhfp_pkg;

   localparam int DATA_W = 16;
   localparam int ADDR_HI = 7;
   localparam int ADDR_LO = 1;
   localparam int FIFO_ADDR_HI = 2;
   localparam int CNT_W = 5;
   localparam logic [CNT_W-1:0] BURST_MAX = 5'h10;
   localparam logic [CNT_W-1:0] CNT_FIRST = 5'h01;
   localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
   localparam logic [ADDR_HI:ADDR_LO] ADDR_RST = 7'h00;

   typedef struct packed {
      logic cs_n;
      logic rd_n;
      logic wr_n;
      logic sel;
      logic [ADDR_HI:ADDR_LO] addr;
      logic [DATA_W-1:0] data;
   } slhfp_pins_t;

   localparam int PINS_W = $bits(slhfp_pins_t);
   localparam logic [PINS_W-1:0] PINS_IDLE = {3'h7, 1'h0, 7'h00, 16'h0000};

   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_RWAIT = 6'h02,
      ST_RELOAD = 6'h04,
      ST_FETCH = 6'h08,
      ST_RD = 6'h10,
      ST_WR = 6'h20
   } slhfp_state_t;

endpackage : slhfp_pkg

/* File: slhfp_port.sv */
`timescale 1ns/1ps
module slhfp_port
   import slhfp_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic host_select_n,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic fifo_sel,
   input wire logic [ADDR_HI:ADDR_LO] host_addr,
   input wire logic [DATA_W-1:0] host_data_in,
   output logic [DATA_W-1:0] host_data_out,
   output logic host_data_oe,
   output logic reg_rd_req,
   output logic [ADDR_HI:ADDR_LO] reg_rd_addr,
   input wire logic reg_rd_ack,
   input wire logic [DATA_W-1:0] reg_rd_data,
   output logic reg_wr_en,
   output logic [ADDR_HI:ADDR_LO] reg_wr_addr,
   output logic [DATA_W-1:0] reg_wr_data,
   input wire logic [DATA_W-1:0] rx_fifo_data,
   input wire logic rx_fifo_valid,
   output logic rx_fifo_pop,
   output logic [DATA_W-1:0] tx_fifo_data,
   output logic tx_fifo_push,
   input wire logic tx_fifo_ready,
   output logic rx_underrun,
   output logic tx_overflow,
   output logic burst_overrun
);

   typedef struct packed {
      slhfp_state_t st;
      logic [DATA_W-1:0] data;
      logic oe;
      logic [ADDR_HI:ADDR_LO] addr;
      logic sel;
      logic live;
      logic [CNT_W-1:0] cnt;
      logic rd_req;
      logic rx_pop;
      logic tx_push;
      logic reg_wr;
      logic [DATA_W-1:0] wdata;
      logic rx_under;
      logic tx_over;
      logic burst_over;
   } slhfp_ctl_t;

   slhfp_ctl_t q;
   slhfp_ctl_t d;
   slhfp_pins_t fp;
   logic rd_act;
   logic wr_act;
   logic addr_moved;

   slhfp_pin_if pin_bus ();

   assign pin_bus.raw = '{
      cs_n: host_select_n,
      rd_n: read_strobe_n,
      wr_n: write_strobe_n,
      sel: fifo_sel,
      addr: host_addr,
      data: host_data_in
   };

   // Every pin passes the same filter, so data keeps its setup to the strobe
   // select timed as address
   slhfp_sync u_sync (
      .clock(clock),
      .rst_n(rst_n),
      .pins(pin_bus)
   );

   assign fp = pin_bus.filt;

   assign rd_act = ~fp.cs_n & ~fp.rd_n;
   assign wr_act = ~fp.cs_n & ~fp.wr_n;

   // only A[2:1] marks a new word in FIFO mode (sel high); register mode compares the whole address
   always_comb begin
      if (q.sel) begin
         addr_moved = fp.addr[FIFO_ADDR_HI:ADDR_LO]
            != q.addr[FIFO_ADDR_HI:ADDR_LO];
      end else begin
         addr_moved = fp.addr != q.addr;
      end
   end

   always_comb begin
      d = q;
      d.rd_req = 1'b0;
      d.rx_pop = 1'b0;
      d.tx_push = 1'b0;
      d.reg_wr = 1'b0;
      d.rx_under = 1'b0;
      d.tx_over = 1'b0;
      d.burst_over = 1'b0;
      case (q.st)
         ST_IDLE: begin
            // Wait out a pop so the FIFO head has moved on
            if (rd_act && !q.rx_pop) begin
               d.oe = 1'b1;
               d.addr = fp.addr;
               d.sel = fp.sel;
               d.cnt = CNT_FIRST;
               if (fp.sel) begin
                  d.data = rx_fifo_valid ? rx_fifo_data : DATA_RST;
                  d.live = rx_fifo_valid;
                  d.rx_under = ~rx_fifo_valid;
                  d.st = ST_RD;
               end else begin
                  d.rd_req = 1'b1;
                  d.live = 1'b0;
                  d.st = ST_RWAIT;
               end
            end else if (wr_act) begin
               d.addr = fp.addr;
               d.sel = fp.sel;
               d.wdata = fp.data;
               d.st = ST_WR;
            end
         end
         ST_RWAIT: begin
            if (!rd_act) begin
               d.oe = 1'b0;
               d.st = ST_IDLE;
            end else if (reg_rd_ack) begin
               d.data = reg_rd_data;
               d.st = ST_RD;
            end
         end
         ST_RELOAD: begin
            // Pop is seen by the FIFO this cycle; new head next cycle
            d.st = rd_act ? ST_FETCH : ST_IDLE;
            d.oe = rd_act;
         end
         ST_FETCH: begin
            if (!rd_act) begin
               d.oe = 1'b0;
               d.st = ST_IDLE;
            end else begin
               d.data = rx_fifo_valid ? rx_fifo_data : DATA_RST;
               d.live = rx_fifo_valid;
               d.rx_under = ~rx_fifo_valid;
               d.st = ST_RD;
            end
         end
         ST_RD: begin
            if (!rd_act) begin
               d.oe = 1'b0;
               d.st = ST_IDLE;
               d.rx_pop = q.sel & q.live;
               d.live = 1'b0;
            end else if (addr_moved) begin
               d.addr = fp.addr;
               if (q.sel) begin
                  d.rx_pop = q.live;
                  d.live = 1'b0;
                  d.st = ST_RELOAD;
               end else if (q.cnt < BURST_MAX) begin
                  d.cnt = q.cnt + CNT_FIRST;
                  d.rd_req = 1'b1;
                  d.st = ST_RWAIT;
               end else begin
                  // Word beyond the limit keeps old data
                  d.burst_over = 1'b1;
               end
            end
         end
         ST_WR: begin
            if (wr_act) begin
               // Last word seen while active; data hold may be zero
               d.wdata = fp.data;
            end else begin
               d.st = ST_IDLE;
               if (q.sel) begin
                  d.tx_push = tx_fifo_ready;
                  d.tx_over = ~tx_fifo_ready;
               end else begin
                  d.reg_wr = 1'b1;
               end
            end
         end
         default: begin
            d.st = ST_IDLE;
            d.oe = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         q <= '{
            st: ST_IDLE,
            data: DATA_RST,
            oe: 1'b0,
            addr: ADDR_RST,
            sel: 1'b0,
            live: 1'b0,
            cnt: '0,
            rd_req: 1'b0,
            rx_pop: 1'b0,
            tx_push: 1'b0,
            reg_wr: 1'b0,
            wdata: DATA_RST,
            rx_under: 1'b0,
            tx_over: 1'b0,
            burst_over: 1'b0
         };
      end else begin
         q <= d;
      end
   end

   assign host_data_out = q.data;
   assign host_data_oe = q.oe;
   assign reg_rd_req = q.rd_req;
   assign reg_rd_addr = q.addr;
   assign reg_wr_en = q.reg_wr;
   assign reg_wr_addr = q.addr;
   assign reg_wr_data = q.wdata;
   assign rx_fifo_pop = q.rx_pop;
   assign tx_fifo_data = q.wdata;
   assign tx_fifo_push = q.tx_push;
   assign rx_underrun = q.rx_under;
   assign tx_overflow = q.tx_over;
   assign burst_overrun = q.burst_over;

endmodule : slhfp_port

/* File: slhfp_props.sv */
`timescale 1ns/1ps
module slhfp_props (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic host_select_n,
   input wire logic read_strobe_n,
   input wire logic host_data_oe,
   input wire logic rx_fifo_pop,
   input wire logic reg_rd_req,
   input wire logic reg_wr_en,
   input wire logic tx_fifo_push,
   input wire logic tx_overflow
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   // Filter latency bounds the window
   chk_oe_start: assert property ($rose(host_data_oe) |-> !$past(host_select_n, 3) && !$past(read_strobe_n, 3)) else $error("oe rose without read");
   chk_oe_end: assert property (read_strobe_n [*8] |-> !host_data_oe) else $error("oe held after read end");
   chk_pop_idle: assert property (host_select_n [*8] |-> !rx_fifo_pop) else $error("pop while deselected");
   chk_pop_no_req: assert property (rx_fifo_pop |-> !reg_rd_req) else $error("register read in fifo mode");
   chk_ovf_no_push: assert property (tx_overflow |-> !tx_fifo_push) else $error("push on overflow");
   chk_push_no_oe: assert property (tx_fifo_push |-> !host_data_oe) else $error("push during read");
   chk_wr_single: assert property (reg_wr_en |=> !reg_wr_en) else $error("write pulse too long");
   chk_req_single: assert property (reg_rd_req |=> !reg_rd_req) else $error("read request too long");
   chk_push_single: assert property (tx_fifo_push |=> !tx_fifo_push) else $error("push pulse too long");
endmodule : slhfp_props
bind slhfp_port slhfp_props u_props (.clock, .rst_n, .host_select_n,
   .read_strobe_n, .host_data_oe, .rx_fifo_pop, .reg_rd_req, .reg_wr_en,
   .tx_fifo_push, .tx_overflow);

/* File: slhfp_sync.sv */
`timescale 1ns/1ps
module slhfp_sync
   import slhfp_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   slhfp_pin_if.sampler pins
);

   typedef struct packed {
      logic [PINS_W-1:0] st1;
      logic [PINS_W-1:0] st2;
      logic [PINS_W-1:0] st3;
      logic [PINS_W-1:0] filt;
   } slhfp_sync_t;

   slhfp_sync_t q;
   slhfp_sync_t d;
   logic [PINS_W-1:0] agree;

   // First stage feeds only the second; a bit moves once 2 and 3 agree
   always_comb begin
      d = q;
      d.st1 = pins.raw;
      d.st2 = q.st1;
      d.st3 = q.st2;
      agree = q.st2 ~^ q.st3;
      d.filt = (agree & q.st2) | (~agree & q.filt);
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         q <= {PINS_IDLE, PINS_IDLE, PINS_IDLE, PINS_IDLE};
      end else begin
         q <= d;
      end
   end

   assign pins.filt = q.filt;

endmodule : slhfp_sync

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench
   import slhfp_pkg::*;
;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic oe, pop, push, rreq, wen, ovf, urun, bovr;
   logic h_cs_n, h_rd_n, h_wr_n, h_sel;
   logic [ADDR_HI:ADDR_LO] h_addr;
   logic [DATA_W-1:0] h_data;
   logic valid = 1'b1;
   logic ack = 1'b0;
   logic ready = 1'b1;
   logic [ADDR_HI:ADDR_LO] rd_addr, wr_addr, wa_last;
   logic [DATA_W-1:0] dout, wr_data, tx_data, tx_last, wr_last, head;
   int fails = 0;
   int tests_run = 0;
   int pops = 0, reqs = 0, pushes = 0, ovfs = 0, bovs = 0, unders = 0;
   always #5 clock = ~clock;
   assign head = 16'hc000 + 16'(pops);
   slhfp_host host (.clock(clock), .cs_n(h_cs_n), .rd_n(h_rd_n),
      .wr_n(h_wr_n), .sel(h_sel), .addr(h_addr), .data(h_data));
   slhfp_port dut (.clock(clock), .rst_n(rst_n),
      .host_select_n(h_cs_n), .read_strobe_n(h_rd_n),
      .write_strobe_n(h_wr_n), .fifo_sel(h_sel),
      .host_addr(h_addr), .host_data_in(h_data),
      .host_data_out(dout), .host_data_oe(oe), .reg_rd_req(rreq),
      .reg_rd_addr(rd_addr), .reg_rd_ack(ack),
      .reg_rd_data({9'h1a5, rd_addr}), .reg_wr_en(wen),
      .reg_wr_addr(wr_addr), .reg_wr_data(wr_data), .rx_fifo_data(head),
      .rx_fifo_valid(valid), .rx_fifo_pop(pop), .tx_fifo_data(tx_data),
      .tx_fifo_push(push), .tx_fifo_ready(ready), .rx_underrun(urun),
      .tx_overflow(ovf), .burst_overrun(bovr));
   always @(posedge clock) begin
      if (pop === 1'b1) pops++;
      if (rreq === 1'b1) reqs++;
      if (ovf === 1'b1) ovfs++;
      if (bovr === 1'b1) bovs++;
      if (urun === 1'b1) unders++;
      if (push === 1'b1) begin
         pushes++;
         tx_last = tx_data;
      end
      if (wen === 1'b1) begin
         wa_last = wr_addr;
         wr_last = wr_data;
      end
      ack <= rreq;
   end
   task automatic check(input string n, input logic [15:0] e, g);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : check
   task automatic results;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : results
   task automatic t_reg_read;
      host.rd_on(1'b0, 7'h15);
      check("reg_rd_addr", 16'(7'h15), 16'(rd_addr));
      check("reg data", {9'h1a5, 7'h15}, dout);
      host.rd_off();
      check("oe off", 16'h0, 16'(oe));
      $display("t_reg_read done");
   endtask : t_reg_read
   task automatic t_burst;
      int p0;
      int r0;
      p0 = pops;
      r0 = reqs;
      // Upper bits vary; past 16 words
      host.rd_on(1'b1, 7'h78);
      for (int i = 0; i < 20; i++) begin
         if (i > 0) host.next_addr(7'(i * 9));
         check("rx data", 16'hc000 + 16'(p0 + i), dout);
      end
      host.next_addr(h_addr ^ 7'h78);
      check("upper only", 16'hc000 + 16'(p0 + 19), dout);
      host.rd_off();
      check("pops", 16'(p0 + 20), 16'(pops));
      check("reg reqs", 16'(r0), 16'(reqs));
      $display("t_burst done");
   endtask : t_burst
   task automatic t_write;
      int p0;
      int o0;
      host.wr(1'b0, 7'h2b, 16'h1234);
      check("wr addr", 16'(7'h2b), 16'(wa_last));
      check("wr data", 16'h1234, wr_last);
      p0 = pushes;
      o0 = ovfs;
      host.wr(1'b1, 7'h7f, 16'hbeef);
      check("tx data", 16'hbeef, tx_last);
      ready = 1'b0;
      host.wr(1'b1, 7'h05, 16'h0bad);
      ready = 1'b1;
      check("pushes", 16'(p0 + 1), 16'(pushes));
      check("overflows", 16'(o0 + 1), 16'(ovfs));
      $display("t_write done");
   endtask : t_write
   task automatic t_reg_burst;
      int b0;
      int r0;
      logic [ADDR_HI:ADDR_LO] a;
      b0 = bovs;
      r0 = reqs;
      // Seventeenth word is refused and keeps the sixteenth
      host.rd_on(1'b0, 7'h40);
      for (int i = 0; i < 17; i++) begin
         if (i > 0) host.next_addr(7'h40 + 7'(i));
         a = 7'h40 + 7'((i < 16) ? i : 15);
         check("burst data", {9'h1a5, a}, dout);
      end
      check("burst overruns", 16'(b0 + 1), 16'(bovs));
      check("burst reqs", 16'(r0 + 16), 16'(reqs));
      host.rd_off();
      $display("t_reg_burst done");
   endtask : t_reg_burst
   task automatic t_underrun;
      int p0;
      int u0;
      p0 = pops;
      u0 = unders;
      valid = 1'b0;
      host.rd_on(1'b1, 7'h02);
      check("empty data", 16'h0000, dout);
      host.rd_off();
      valid = 1'b1;
      check("underruns", 16'(u0 + 1), 16'(unders));
      check("empty pops", 16'(p0), 16'(pops));
      $display("t_underrun done");
   endtask : t_underrun
   initial begin
      repeat (2) @(posedge clock);
      #1 rst_n = 1'b1;
      t_reg_read();
      t_burst();
      t_write();
      t_reg_burst();
      t_underrun();
      results();
   end
   initial begin
      #200000;
      fails++;
      results();
   end
endmodule : testbench
